// ---- core/chra_pkg.sv ----
// package: constants and types for the core halt/run arbitration block
package chra_pkg;
	localparam logic [11:0] CSR_PAUSE_CYCLE_CONTROL = 12'h7c2;
	localparam logic [11:0] CSR_POWER_HALT_CONTROL = 12'h7c6;
	localparam int HALT_BIT = 0;
	localparam logic [31:0] PAUSE_RESET = 32'h0;
	localparam logic [31:0] READ_ZERO = 32'h0;
	localparam int QUIESCE_CYCLES_DEF = 4;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		ST_RUNNING = 3'b001,
		ST_POWER_HALTED = 3'b010,
		ST_DEBUG_HALTED = 3'b100
	} chra_state_type;
endpackage

// ---- core/chra_sync.sv ----
// file: two-flop synchroniser bank for asynchronous handshake inputs
`timescale 1ns/1ps
`default_nettype none
module chra_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;
	// first stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			meta <= '0;
			o_sync <= '0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule // chra_sync
`default_nettype wire

// ---- core/chra_core_halt_run.sv ----
// file: core activity state arbiter, firmware halt and pause counter
//
// Summary of operation
// - controller halt while running enters debug halt, then acknowledges.
// - controller halt is acknowledged even if already debug halted.
// - controller run during debugger operation keeps halt, withholds ack.
// - after debugger resume stay halted while controller halt outstanding.
// - both halt sources must each issue run before leaving debug halt.
// - leaving debug halt: running, drop debug mode, then ack run.
// - power halt wakes on run request, timers, nmi, enabled wake.
// - halted: only top-priority wake counts, needs both interrupt enables.
// - pending interrupts serviced after return to running.
// - writing one to halt bit starts quiesce then power halt.
// - halt bit reads zero; write ignored in debug mode.
// - dma stays serviced in both halted states.
// - reserved bits read zero; writable fields accept any value.
// - pause write stalls; counts down each cycle; ends at zero/interrupt.
// - pause field accepts any value, reads zero.
// - pause keeps the running state, not power management.
// - internal timer interrupt ends a pause.
// - power halt during pause freezes countdown until running.
// - pause length may skid a few cycles.
// - wait-for-interrupt acts as no-operation.
// - controller debug handshakes: ack held until request falls.
// - power manager handshakes: ack held until request falls.
// - breakpoint status drops on exit from debug mode.
`timescale 1ns/1ps
`default_nettype none
module chra_core_halt_run
	import chra_pkg::*;
#(
	parameter int QUIESCE_CYCLES = QUIESCE_CYCLES_DEF
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_cpu_halt_req,
	input wire logic i_cpu_run_req,
	input wire logic i_mpc_debug_halt_req,
	input wire logic i_mpc_debug_run_req,
	input wire logic i_dbg_halt_req,
	input wire logic i_dbg_resume_req,
	input wire logic i_dbg_busy,
	input wire logic i_brkpt_hit,
	input wire logic i_timer_int,
	input wire logic i_int_timer_int,
	input wire logic i_nmi_int,
	input wire logic i_hi_wakeup,
	input wire logic i_any_int,
	input wire logic i_mstatus_mie,
	input wire logic i_mie_meie,
	input wire logic i_pipe_idle,
	input wire logic i_wfi,
	input wire logic i_csr_wr,
	input wire logic i_csr_rd,
	input wire logic [11:0] i_csr_addr,
	input wire logic [31:0] i_csr_wdata,
	input wire logic i_dma_req,
	output logic [31:0] o_csr_rdata,
	output logic o_csr_hit,
	output logic o_cpu_halt_ack,
	output logic o_cpu_run_ack,
	output logic o_cpu_halt_status,
	output logic o_mpc_debug_halt_ack,
	output logic o_mpc_debug_run_ack,
	output logic o_debug_mode_status,
	output logic o_debug_brkpt_status,
	output logic o_exec_stall,
	output logic o_int_service_en,
	output logic o_dma_grant
);
	// ************************************************************
	// input synchronisation
	// ************************************************************
	logic [3:0] sync_out;
	chra_sync #(.WIDTH(4)) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_async({i_cpu_halt_req, i_cpu_run_req,
			i_mpc_debug_halt_req, i_mpc_debug_run_req}),
		.o_sync(sync_out)
	);
	wire pm_halt_req = sync_out[3];
	wire pm_run_req = sync_out[2];
	wire mc_halt_req = sync_out[1];
	wire mc_run_req = sync_out[0];

	// ************************************************************
	// state and flags
	// ************************************************************
	chra_state_type state;
	chra_state_type next_state;
	logic dbg_flag;
	logic mc_flag;
	logic fw_halt_pend;
	logic [31:0] quiesce_cnt;
	logic [31:0] pause_cnt;
	logic mc_run_pend;

	wire in_debug = dbg_flag | mc_flag;
	wire wr_halt_ctl = i_csr_wr && (i_csr_addr == CSR_POWER_HALT_CONTROL);
	wire wr_pause = i_csr_wr && (i_csr_addr == CSR_PAUSE_CYCLE_CONTROL);
	wire fw_halt_set = wr_halt_ctl && i_csr_wdata[HALT_BIT] && !in_debug;
	wire wake_hi = i_hi_wakeup && i_mstatus_mie && i_mie_meie;
	wire wake = pm_run_req | i_timer_int | i_int_timer_int | i_nmi_int
		| wake_hi;
	wire halt_want = (pm_halt_req | fw_halt_pend) && !in_debug;
	wire quiesced = i_pipe_idle && (quiesce_cnt >= 32'(QUIESCE_CYCLES));
	// debugger resume clears its flag only when no operation in flight
	wire dbg_clear = i_dbg_resume_req && !i_dbg_busy;
	wire mc_clear = mc_run_pend && o_mpc_debug_halt_ack == 1'b0;
	wire next_dbg = (dbg_flag | i_dbg_halt_req) & ~dbg_clear;
	wire next_mc = (mc_flag | (mc_halt_req & ~o_mpc_debug_halt_ack))
		& ~(mc_clear & ~mc_halt_req);
	wire pause_end = (pause_cnt == PAUSE_RESET) | i_any_int
		| i_int_timer_int;
	wire pause_dec = (state == ST_RUNNING) && !pause_end;
	wire hit_pause = (i_csr_addr == CSR_PAUSE_CYCLE_CONTROL);
	wire hit_halt = (i_csr_addr == CSR_POWER_HALT_CONTROL);

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_RUNNING: begin
				if (next_dbg | next_mc) begin
					next_state = ST_DEBUG_HALTED;
				end else if (halt_want && quiesced) begin
					next_state = ST_POWER_HALTED;
				end
			end
			ST_POWER_HALTED: begin
				if (next_dbg | next_mc) begin
					next_state = ST_DEBUG_HALTED;
				end else if (wake) begin
					next_state = ST_RUNNING;
				end
			end
			ST_DEBUG_HALTED: begin
				if (!next_dbg && !next_mc) begin
					next_state = ST_RUNNING;
				end
			end
			default: begin
				next_state = ST_RUNNING;
			end
		endcase
	end

	// ************************************************************
	// sequential state
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state <= ST_RUNNING;
			dbg_flag <= 1'b0;
			mc_flag <= 1'b0;
			mc_run_pend <= 1'b0;
		end else begin
			state <= next_state;
			dbg_flag <= next_dbg;
			mc_flag <= next_mc;
			// run request only clears controller flag once latched
			mc_run_pend <= mc_run_req & mc_flag;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			fw_halt_pend <= 1'b0;
			quiesce_cnt <= 32'h0;
		end else begin
			if (fw_halt_set) begin
				fw_halt_pend <= 1'b1;
			end else if (state != ST_RUNNING) begin
				fw_halt_pend <= 1'b0;
			end
			if (halt_want && state == ST_RUNNING && i_pipe_idle) begin
				quiesce_cnt <= quiesce_cnt + 32'h1;
			end else begin
				quiesce_cnt <= 32'h0;
			end
		end
	end

	// pause counter; state untouched, skid tolerated
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pause_cnt <= PAUSE_RESET;
		end else if (wr_pause) begin
			pause_cnt <= i_csr_wdata;
		end else if (pause_end && state == ST_RUNNING) begin
			pause_cnt <= PAUSE_RESET;
		end else if (pause_dec) begin
			pause_cnt <= pause_cnt - 32'h1;
		end
	end

	// ************************************************************
	// handshakes and status outputs
	// ************************************************************
	wire next_mc_halt_ack = mc_halt_req & (state == ST_DEBUG_HALTED)
		& mc_flag;
	// run ack only once running and debug mode dropped
	wire next_mc_run_ack = mc_run_req & (state == ST_RUNNING)
		& !o_debug_mode_status & !mc_flag;
	wire next_pm_halt_ack = pm_halt_req & (state == ST_POWER_HALTED);
	wire next_pm_run_ack = pm_run_req & (state == ST_RUNNING);
	wire next_brkpt = (o_debug_brkpt_status | i_brkpt_hit)
		& (next_state == ST_DEBUG_HALTED);

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_mpc_debug_halt_ack <= 1'b0;
			o_mpc_debug_run_ack <= 1'b0;
			o_cpu_halt_ack <= 1'b0;
			o_cpu_run_ack <= 1'b0;
			o_cpu_halt_status <= 1'b0;
			o_debug_mode_status <= 1'b0;
			o_debug_brkpt_status <= 1'b0;
			o_exec_stall <= 1'b0;
			o_int_service_en <= 1'b0;
			o_dma_grant <= 1'b0;
		end else begin
			o_mpc_debug_halt_ack <= next_mc_halt_ack;
			o_mpc_debug_run_ack <= next_mc_run_ack;
			o_cpu_halt_ack <= next_pm_halt_ack;
			o_cpu_run_ack <= next_pm_run_ack;
			o_cpu_halt_status <= (next_state == ST_POWER_HALTED);
			o_debug_mode_status <= (next_state == ST_DEBUG_HALTED);
			o_debug_brkpt_status <= next_brkpt;
			// wfi ignored: no effect on stall or state
			o_exec_stall <= (next_state != ST_RUNNING)
				| (wr_pause | !pause_end);
			o_int_service_en <= (next_state == ST_RUNNING);
			o_dma_grant <= i_dma_req;
		end
	end

	// ************************************************************
	// csr read port
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_csr_rdata <= READ_ZERO;
			o_csr_hit <= 1'b0;
		end else begin
			o_csr_rdata <= READ_ZERO;
			o_csr_hit <= (i_csr_rd | i_csr_wr) & (hit_pause | hit_halt);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	chk_run_ack_order: assert property (
		o_mpc_debug_run_ack |-> !o_debug_mode_status && state == ST_RUNNING)
		else $error("run ack while still in debug mode");
	chk_halt_ack_state: assert property (
		$rose(o_mpc_debug_halt_ack) |-> $past(state) == ST_DEBUG_HALTED)
		else $error("halt ack before debug halt");
	chk_both_runs: assert property (
		(state == ST_DEBUG_HALTED && dbg_flag) |=> state != ST_RUNNING
			|| $past(dbg_clear))
		else $error("left debug halt with debugger halt pending");
	chk_busy_hold: assert property (
		(state == ST_DEBUG_HALTED && dbg_flag && i_dbg_busy) |=>
			state == ST_DEBUG_HALTED)
		else $error("left debug halt during debugger operation");
	chk_halt_rd_zero: assert property (
		o_csr_rdata == READ_ZERO)
		else $error("control register read nonzero");
	chk_pause_state: assert property (
		(state == ST_RUNNING && wr_pause && !in_debug && !halt_want) |=>
			state == ST_RUNNING)
		else $error("pause changed activity state");
	chk_pause_freeze: assert property (
		(state == ST_POWER_HALTED && !wr_pause && $past(state)
			== ST_POWER_HALTED) |-> $stable(pause_cnt))
		else $error("pause count moved while power halted");
	chk_brkpt_exit: assert property (
		!o_debug_mode_status |-> !o_debug_brkpt_status)
		else $error("breakpoint status outside debug mode");
	chk_wake_gate: assert property (
		(state == ST_POWER_HALTED && !in_debug && !next_dbg && !next_mc
			&& !pm_run_req && !i_timer_int && !i_int_timer_int
			&& !i_nmi_int && !(i_mstatus_mie && i_mie_meie))
			|=> state == ST_POWER_HALTED)
		else $error("woke without enabled wake event");
	chk_fw_debug: assert property (
		(wr_halt_ctl && in_debug) |=> !$rose(fw_halt_pend))
		else $error("halt write taken in debug mode");

	cov_mc_halt: cover property (o_mpc_debug_halt_ack);
	cov_mc_run: cover property (o_mpc_debug_run_ack);
	cov_pm_halt: cover property (state == ST_POWER_HALTED);
	cov_pause: cover property (pause_dec ##3 pause_dec);
endmodule // chra_core_halt_run
`default_nettype wire

// ---- testbench/chra_far_model.sv ----
// far-side model: power manager and multi-core debug controller handshakes
`timescale 1ns/1ps
`default_nettype none
module chra_far_model (
	input wire logic i_clk,
	input wire logic [3:0] i_ack,
	output var logic [3:0] o_req,
	output var logic o_late
);
	// ****************
	// four-phase handshake engine
	// ****************
	initial begin
		o_req = 4'h0;
		o_late = 1'b0;
	end
	// k: 0 power halt, 1 power run, 2 debug halt, 3 debug run
	task automatic hs(input int k);
		int n;
		@(negedge i_clk);
		o_req[k] = 1'b1;
		for (n = 0; n < 60 && i_ack[k] !== 1'b1; n++)
			@(negedge i_clk);
		o_late = o_late | (n == 60);
		// request drops once ack is seen or after 60 cycles without it
		o_req[k] = 1'b0;
		for (n = 0; n < 60 && i_ack[k] !== 1'b0; n++)
			@(negedge i_clk);
		o_late = o_late | (n == 60);
	endtask
endmodule // chra_far_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the core halt/run arbiter
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import chra_pkg::*;
	// ****************
	// stimulus, instances and scenarios
	// ****************
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic dh = 1'b0, dr = 1'b0, busy = 1'b0, brk = 1'b0, mie = 1'b0;
	logic meie = 1'b0, idle = 1'b1, wfi = 1'b0, wr = 1'b0, rd = 1'b0;
	logic dma = 1'b0;
	logic [4:0] ev = 5'h0; // timer, int timer, nmi, top wake, any int
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic hit, hack, rack, hst, mhack, mrack, dmode, brks, stall, isen, dg;
	logic late;
	logic [3:0] req;
	wire logic [3:0] acks;
	wire logic pm_h, pm_r, mc_h, mc_r;
	wire logic ev_tmr, ev_itmr, ev_nmi, ev_hi, ev_any;
	assign acks = {mrack, mhack, rack, hack};
	assign {mc_r, mc_h, pm_r, pm_h} = req;
	assign {ev_any, ev_hi, ev_nmi, ev_itmr, ev_tmr} = ev;
	int failures = 0;
	int compares = 0;
	always #2.5 i_clk = ~i_clk;
	chra_far_model far_u (.i_clk(i_clk), .i_ack(acks),
		.o_req(req), .o_late(late));
	chra_core_halt_run #(.QUIESCE_CYCLES(4)) dut_u (.i_clk(i_clk),
		.i_nrst(i_nrst), .i_cpu_halt_req(pm_h), .i_cpu_run_req(pm_r),
		.i_mpc_debug_halt_req(mc_h), .i_mpc_debug_run_req(mc_r),
		.i_dbg_halt_req(dh), .i_dbg_resume_req(dr), .i_dbg_busy(busy),
		.i_brkpt_hit(brk), .i_timer_int(ev_tmr),
		.i_int_timer_int(ev_itmr), .i_nmi_int(ev_nmi),
		.i_hi_wakeup(ev_hi), .i_any_int(ev_any),
		.i_mstatus_mie(mie), .i_mie_meie(meie), .i_pipe_idle(idle),
		.i_wfi(wfi), .i_csr_wr(wr), .i_csr_rd(rd), .i_csr_addr(addr),
		.i_csr_wdata(wdata), .i_dma_req(dma), .o_csr_rdata(rdata),
		.o_csr_hit(hit), .o_cpu_halt_ack(hack), .o_cpu_run_ack(rack),
		.o_cpu_halt_status(hst), .o_mpc_debug_halt_ack(mhack),
		.o_mpc_debug_run_ack(mrack), .o_debug_mode_status(dmode),
		.o_debug_brkpt_status(brks), .o_exec_stall(stall),
		.o_int_service_en(isen), .o_dma_grant(dg));
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic csr(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(negedge i_clk);
		wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(negedge i_clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task automatic dbg(input logic h);
		@(negedge i_clk);
		dh = h;
		dr = !h;
		@(negedge i_clk);
		dh = 1'b0;
		dr = 1'b0;
	endtask
	task automatic t_mpc;
		dma = 1'b1;
		far_u.hs(2);
		chk("dmode", dmode, 1);
		chk("dma", dg, 1);
		far_u.hs(3);
		chk("dmode", dmode, 0);
		chk("late", late, 0);
	endtask
	task automatic t_busy;
		dbg(1'b1);
		brk = 1'b1;
		cyc(1);
		brk = 1'b0;
		far_u.hs(2);
		chk("late", late, 0);
		busy = 1'b1;
		fork
			far_u.hs(3);
		join_none
		cyc(14);
		chk("rack", mrack, 0);
		chk("dmode", dmode, 1);
		busy = 1'b0;
		dbg(1'b0);
		wait fork;
		chk("dmode", dmode, 0);
		chk("brk", brks, 0);
		chk("late", late, 0);
	endtask
	task automatic t_resume;
		far_u.hs(2);
		dbg(1'b1);
		cyc(6);
		dbg(1'b0);
		csr(1'b1, CSR_POWER_HALT_CONTROL, 32'h1);
		cyc(10);
		chk("dmode", dmode, 1);
		far_u.hs(3);
		cyc(20);
		chk("dmode", dmode, 0);
		chk("halt", hst, 0);
	endtask
	task automatic t_wake;
		// a busy pipeline holds off the halt until it goes quiet
		idle = 1'b0;
		csr(1'b1, CSR_POWER_HALT_CONTROL, 32'h1);
		cyc(12);
		chk("halt", hst, 0);
		idle = 1'b1;
		cyc(12);
		chk("halt", hst, 1);
		chk("dma", dg, 1);
		ev[0] = 1'b1;
		cyc(4);
		chk("halt", hst, 0);
		ev = 5'h0;
		for (int i = 0; i < 4; i++) begin
			csr(1'b1, CSR_POWER_HALT_CONTROL, 32'hffffffff);
			cyc(12);
			chk("halt", hst, 1);
			ev = 5'h18;
			cyc(8);
			chk("halt", hst, 1);
			ev = 5'h0;
			mie = 1'b1;
			meie = 1'b1;
			ev[i] = 1'b1;
			cyc(8);
			chk("halt", hst, 0);
			chk("isen", isen, 1);
			ev = 5'h0;
			mie = 1'b0;
			meie = 1'b0;
		end
		csr(1'b0, CSR_POWER_HALT_CONTROL, 32'h0);
		chk("hit", hit, 1);
		chk("rdata", rdata, 0);
		csr(1'b0, CSR_PAUSE_CYCLE_CONTROL, 32'h0);
		chk("rdata", rdata, 0);
		csr(1'b0, 12'h7c0, 32'h0);
		chk("hit", hit, 0);
		far_u.hs(0);
		chk("halt", hst, 1);
		far_u.hs(1);
		chk("halt", hst, 0);
	endtask
	task automatic t_pause;
		wfi = 1'b1;
		cyc(6);
		chk("stall", stall, 0);
		chk("halt", hst, 0);
		wfi = 1'b0;
		csr(1'b1, CSR_PAUSE_CYCLE_CONTROL, 32'h14);
		cyc(2);
		chk("stall", stall, 1);
		chk("halt", hst, 0);
		cyc(30);
		chk("stall", stall, 0);
		csr(1'b1, CSR_PAUSE_CYCLE_CONTROL, 32'h3e8);
		cyc(4);
		ev[1] = 1'b1;
		cyc(6);
		chk("stall", stall, 0);
		ev = 5'h0;
		csr(1'b1, CSR_PAUSE_CYCLE_CONTROL, 32'h3e8);
		cyc(4);
		chk("stall", stall, 1);
		ev[4] = 1'b1;
		cyc(6);
		chk("stall", stall, 0);
		ev = 5'h0;
		csr(1'b1, CSR_PAUSE_CYCLE_CONTROL, 32'h28);
		far_u.hs(0);
		cyc(60);
		far_u.hs(1);
		chk("stall", stall, 1);
		cyc(45);
		chk("stall", stall, 0);
		chk("late", late, 0);
	endtask
	task automatic stop_test;
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// generous span: the whole sequence needs well under 2000 cycles
	initial begin
		repeat (6000) @(posedge i_clk);
		failures++;
		stop_test();
	end
	initial begin
		cyc(12);
		i_nrst = 1'b1;
		cyc(2);
		t_mpc();
		t_busy();
		t_resume();
		t_wake();
		t_pause();
		stop_test();
	end
endmodule // testbench
`default_nettype wire
